// ---- rtl/aam_pkg.sv ----
// Constants, register map and carrier types of the auxiliary converter block.
package aam_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam int NCH = 3;
    localparam int CH_BAT  = 0;
    localparam int CH_TEMP = 1;
    localparam int CH_EXT  = 2;

    localparam logic [7:0] ADDR_TEMP_RESULT = 8'hd7;
    localparam logic [7:0] ADDR_START_ACK   = 8'hd8;
    localparam logic [7:0] ADDR_BAT_RESULT  = 8'hdf;
    localparam logic [7:0] ADDR_EXT_RESULT  = 8'hef;
    localparam logic [7:0] ADDR_DELTA_CFG   = 8'hf3;
    localparam logic [7:0] ADDR_PERIPHERAL_CONFIG_REGISTER_CFG  = 8'hf4;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'hf5;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'hf6;
    localparam logic [7:0] ADDR_STROBE_CFG  = 8'hf9;
    localparam logic [7:0] ADDR_BAT_THRESH  = 8'hfa;

    localparam logic [7:0] RESET_BYTE = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Start register layout: bits 0..2 are request bits indexed by channel.
    localparam int START_ACK_BIT = 7;
    localparam logic [7:0] START_GO_MASK = 8'h07;

    // Delta configuration layout.
    localparam int TEMP_DELTA_HI = 5;
    localparam int TEMP_DELTA_LO = 3;
    localparam int EXT_DELTA_HI  = 2;
    localparam int EXT_DELTA_LO  = 0;
    localparam logic [7:0] DELTA_CFG_MASK = 8'h3f;
    localparam logic [2:0] DELTA_OFF   = 3'h0;
    localparam logic [2:0] DELTA_EVERY = 3'h7;

    // Strobe interval layout.
    localparam int EXT_IVL_LO  = 4;
    localparam int BAT_IVL_LO  = 2;
    localparam int TEMP_IVL_LO = 0;
    localparam logic [7:0] STROBE_CFG_MASK = 8'h3f;
    localparam logic [1:0] IVL_OFF = 2'h0;
    localparam logic [1:0] IVL_SLOW = 2'h1;
    localparam logic [1:0] IVL_MID  = 2'h2;

    localparam logic [4:0] BAT_MIN_SLOW  = 5'h10;
    localparam logic [4:0] BAT_MIN_MID   = 5'h04;
    localparam logic [4:0] ANY_MIN_FAST  = 5'h01;
    localparam logic [4:0] OTH_MIN_SLOW  = 5'h08;
    localparam logic [4:0] OTH_MIN_MID   = 5'h02;

    // Peripheral configuration and interrupt layouts.
    localparam int LOCK_FAULT_BIT = 0;
    localparam int IRQ_LOCK_BIT   = 3;
    localparam logic [7:0] IRQ_MASK_BITS = 8'h0f;

    ////////////////////////////////////////////////////////////////////////
    localparam longint unsigned CLK_HZ    = 100_000_000;
    localparam longint unsigned MINUTE_S  = 60;
    localparam longint unsigned MINUTE_CYCLES_DEF = MINUTE_S * CLK_HZ;

    typedef struct packed {
        logic       ack;
        logic       done;
        logic [7:0] data;
    } aam_conv_rsp_s;

endpackage

// ---- rtl/aam_measure_ctrl.sv ----
// Start, threshold, result and interrupt logic for three auxiliary converters.
//
// Function
// - thermal delta field bits 5:3, 000 off, 111 always.
// - external delta field, same encoding as thermal.
// - bit 2 requests external conversion, self-clears.
// - bit 1 requests temperature conversion, self-clears.
// - bit 0 requests battery conversion, self-clears.
// - start bit 7 clears the lock fault.
// - lock fault set on lock-loss reset, sticky.
// - battery below threshold raises interrupt.
// - result registers load only on interrupt or on a software write.
// - background temperature and external results interrupt when change exceeds threshold.
// - single conversions always interrupt and load.
// - battery interval off, 16, 4, 1 minutes.
// - external interval off, 8, 2, 1 minutes.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps

module aam_measure_ctrl
    import aam_pkg::*;
#(
    parameter logic [39:0] MINUTE_CYCLES = 40'(MINUTE_CYCLES_DEF)
) (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic [7:0]              addr,
    input  wire logic [7:0]              wdata,
    input  wire logic                    wr,
    input  wire logic                    rd,
    output logic      [7:0]              rdata,
    output logic                         irq,
    output logic      [NCH-1:0]          conv_req,
    input  wire aam_conv_rsp_s [NCH-1:0] conv_rsp,
    input  wire logic                    lock_loss_reset
);

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]     delta_cfg;
    logic [7:0]     strobe_cfg;
    logic [7:0]     bat_thresh;
    logic [7:0]     irq_status;
    logic [7:0]     irq_mask;
    logic [7:0]     result [NCH];
    logic [NCH-1:0] go_pending;
    logic [NCH-1:0] single_run;
    logic [NCH-1:0] conv_event;
    logic [NCH-1:0] bg_fire;
    logic           lock_fault;
    logic           lock_sync1;
    logic           lock_sync2;
    logic [39:0]    minute_cnt;
    logic           minute_tick;

    logic wr_start;
    logic wr_delta;
    logic wr_strobe;
    logic wr_thresh;
    logic wr_status;
    logic wr_mask;

    // Each write strobe except the result writes is decoded once here; an address outside the map
    // matches none of them, so a stray write leaves every control bit alone.
    assign wr_start  = wr && (addr == ADDR_START_ACK);
    assign wr_delta  = wr && (addr == ADDR_DELTA_CFG);
    assign wr_strobe = wr && (addr == ADDR_STROBE_CFG);
    assign wr_thresh = wr && (addr == ADDR_BAT_THRESH);
    assign wr_status = wr && (addr == ADDR_IRQ_STATUS);
    assign wr_mask   = wr && (addr == ADDR_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers. Reserved bits are masked on write. The
    // battery threshold has no reserved bits and is stored as written.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            delta_cfg  <= RESET_BYTE;
            strobe_cfg <= RESET_BYTE;
            bat_thresh <= RESET_BYTE;
            irq_mask   <= RESET_BYTE;
        end else begin
            if (wr_delta) begin
                delta_cfg <= wdata & DELTA_CFG_MASK;
            end
            if (wr_strobe) begin
                strobe_cfg <= wdata & STROBE_CFG_MASK;
            end
            if (wr_thresh) begin
                bat_thresh <= wdata;
            end
            if (wr_mask) begin
                irq_mask <= wdata & IRQ_MASK_BITS;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock-loss indication arrives from the reset controller, off this
    // clock, so it is synchronised before use.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lock_sync1 <= 1'b0;
            lock_sync2 <= 1'b0;
        end else begin
            lock_sync1 <= lock_loss_reset;
            lock_sync2 <= lock_sync1;
        end
    end

    // The fault stays set for as long as the synchronised indication is
    // high, so an acknowledge only sticks once the reset controller has
    // let go of it. A new fault in the cycle of the acknowledge still wins.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lock_fault <= 1'b0;
        end else if (lock_sync2) begin
            lock_fault <= 1'b1;
        end else if (wr_start && wdata[START_ACK_BIT]) begin
            lock_fault <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared minute prescaler for the background strobes. One counter for
    // all channels saves area; the price is that every channel's period is
    // aligned to the same minute boundary, so the first background request
    // after enabling an interval may come up to one minute early.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            minute_cnt  <= '0;
            minute_tick <= 1'b0;
        end else if (minute_cnt >= MINUTE_CYCLES - 40'h1) begin
            minute_cnt  <= '0;
            minute_tick <= 1'b1;
        end else begin
            minute_cnt  <= minute_cnt + 40'h1;
            minute_tick <= 1'b0;
        end
    end

    function automatic logic [1:0] ivl_code(input int ch,
                                            input logic [7:0] cfg);
        logic [1:0] c;
        c = cfg[TEMP_IVL_LO +: 2];
        if (ch == CH_BAT) begin
            c = cfg[BAT_IVL_LO +: 2];
        end else if (ch == CH_EXT) begin
            c = cfg[EXT_IVL_LO +: 2];
        end
        return c;
    endfunction

    function automatic logic [4:0] ivl_minutes(input int ch,
                                               input logic [1:0] code);
        logic [4:0] m;
        m = ANY_MIN_FAST;
        if (code == IVL_SLOW) begin
            m = (ch == CH_BAT) ? BAT_MIN_SLOW : OTH_MIN_SLOW;
        end else if (code == IVL_MID) begin
            m = (ch == CH_BAT) ? BAT_MIN_MID : OTH_MIN_MID;
        end
        return m;
    endfunction

    // Address at which software may overwrite each channel's result.
    function automatic logic [7:0] result_addr(input int ch);
        logic [7:0] a;
        a = ADDR_TEMP_RESULT;
        if (ch == CH_BAT) begin
            a = ADDR_BAT_RESULT;
        end else if (ch == CH_EXT) begin
            a = ADDR_EXT_RESULT;
        end
        return a;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Per-channel request, strobe and event logic. The converter takes a
    // request with a one-cycle ack and later returns its sample with a
    // one-cycle done; only one conversion per channel is in flight, so a
    // background strobe that lands while a request pends is merged into it.
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            logic [4:0] min_count;
            logic [1:0] code;
            logic [4:0] period;
            logic [7:0] sample;
            logic [7:0] last;
            logic [7:0] diff;
            logic [2:0] sel;
            logic       bg_hit;
            logic       set_go;

            assign code   = ivl_code(g, strobe_cfg);
            assign period = ivl_minutes(g, code);
            assign set_go = wr_start && wdata[g];

            // A period code of zero holds the counter cleared, so a channel
            // that is switched back on counts a full period of ticks first.
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    min_count  <= '0;
                    bg_fire[g] <= 1'b0;
                end else if (code == IVL_OFF) begin
                    min_count  <= '0;
                    bg_fire[g] <= 1'b0;
                end else if (minute_tick) begin
                    if (min_count + 5'h1 >= period) begin
                        min_count  <= '0;
                        bg_fire[g] <= 1'b1;
                    end else begin
                        min_count  <= min_count + 5'h1;
                        bg_fire[g] <= 1'b0;
                    end
                end else begin
                    bg_fire[g] <= 1'b0;
                end
            end

            // A write of the request bit in the cycle of an acknowledge
            // starts a fresh request rather than being lost.
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    go_pending[g] <= 1'b0;
                    conv_req[g]   <= 1'b0;
                    single_run[g] <= 1'b0;
                end else begin
                    if (set_go) begin
                        go_pending[g] <= 1'b1;
                    end else if (conv_rsp[g].ack && conv_req[g]) begin
                        go_pending[g] <= 1'b0;
                    end
                    if (set_go || bg_fire[g]) begin
                        conv_req[g] <= 1'b1;
                    end else if (conv_rsp[g].ack) begin
                        conv_req[g] <= 1'b0;
                    end
                    if (conv_rsp[g].ack && conv_req[g]) begin
                        single_run[g] <= go_pending[g];
                    end
                end
            end

            // The reference for the change test is the result register
            // itself: it holds the last value that raised an event, unless
            // software has overwritten it, in which case the written value
            // becomes the new reference.
            assign sample = conv_rsp[g].data;
            assign last   = result[g];
            assign diff   = (sample > last) ? sample - last : last - sample;
            assign sel    = (g == CH_TEMP) ?
                            delta_cfg[TEMP_DELTA_HI:TEMP_DELTA_LO] :
                            delta_cfg[EXT_DELTA_HI:EXT_DELTA_LO];

            always_comb begin
                bg_hit = 1'b0;
                if (g == CH_BAT) begin
                    bg_hit = sample < bat_thresh;
                end else if (sel == DELTA_EVERY) begin
                    bg_hit = 1'b1;
                end else if (sel != DELTA_OFF) begin
                    bg_hit = diff > {5'h00, sel};
                end
            end

            // Singles interrupt regardless of any threshold.
            assign conv_event[g] = conv_rsp[g].done &&
                                   (single_run[g] || bg_hit);

            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    result[g] <= RESET_BYTE;
                end else if (conv_event[g]) begin
                    result[g] <= sample;
                end else if (wr && addr == result_addr(g)) begin
                    result[g] <= wdata;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Sticky interrupt status, write one to clear; a new event wins.
    // The lock-loss bit follows the synchronised level, so it re-arms each
    // cycle the indication is high and cannot be cleared until it drops.
    logic [7:0] events;
    logic [7:0] next_status;

    assign events = {4'h0, lock_sync2, conv_event};

    always_comb begin
        next_status = irq_status;
        if (wr_status) begin
            next_status = next_status & ~wdata;
        end
        next_status = (next_status | events) & IRQ_MASK_BITS;
    end

    // The interrupt is registered from the next status value so that it
    // rises in the same cycle as the status bit; a mask write takes effect
    // one cycle later because the old mask is still used here.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_status <= RESET_BYTE;
            irq       <= 1'b0;
        end else begin
            irq_status <= next_status;
            irq        <= |(next_status & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data stands for one cycle only; unmapped addresses read zero.
    // The acknowledge bit of the start register is write-only and reads
    // zero, while the request bits show a conversion still waiting for ack.
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = RESET_BYTE;
        unique case (addr)
            ADDR_TEMP_RESULT: next_rdata = result[CH_TEMP];
            ADDR_BAT_RESULT:  next_rdata = result[CH_BAT];
            ADDR_EXT_RESULT:  next_rdata = result[CH_EXT];
            ADDR_START_ACK:   next_rdata = {5'h00, go_pending};
            ADDR_DELTA_CFG:   next_rdata = delta_cfg;
            ADDR_STROBE_CFG:  next_rdata = strobe_cfg;
            ADDR_BAT_THRESH:  next_rdata = bat_thresh;
            ADDR_PERIPHERAL_CONFIG_REGISTER_CFG:  next_rdata = {7'h00, lock_fault};
            ADDR_IRQ_STATUS:  next_rdata = irq_status;
            ADDR_IRQ_MASK:    next_rdata = irq_mask;
            default:          next_rdata = RESET_BYTE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata <= RESET_BYTE;
        end else if (rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= RESET_BYTE;
        end
    end

endmodule

// ---- sim/aam_assertions.sv ----
// Port-level checks of the auxiliary converter control block.
`timescale 1ns/1ps

module aam_assert_chk
    import aam_pkg::*;
#(
    parameter logic [39:0] MINUTE_CYCLES = 40'd20
) (
    input wire logic                    clk,
    input wire logic                    reset_n,
    input wire logic [7:0]              addr,
    input wire logic [7:0]              wdata,
    input wire logic                    wr,
    input wire logic                    rd,
    input wire logic [7:0]              rdata,
    input wire logic                    irq,
    input wire logic [NCH-1:0]          conv_req,
    input wire aam_conv_rsp_s [NCH-1:0] conv_rsp,
    input wire logic                    lock_loss_reset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic [NCH-1:0] keep;
    logic           any_done;
    logic           mask_wr;
    logic           go_wr;
    assign keep = conv_req & ~{conv_rsp[2].ack, conv_rsp[1].ack,
                               conv_rsp[0].ack};
    assign any_done = conv_rsp[0].done | conv_rsp[1].done | conv_rsp[2].done;
    assign mask_wr = wr && addr == ADDR_IRQ_MASK;
    assign go_wr = wr && addr == ADDR_START_ACK;

    ////////////////////////////////////////////////////////////
    a_go_request: assert property (
        go_wr |=> (conv_req & $past(wdata[2:0])) == $past(wdata[2:0]))
        else $error("start write did not raise its request");
    a_req_stands: assert property (
        (conv_req & $past(keep)) == $past(keep))
        else $error("request dropped without acknowledge");
    // The synchroniser delays the lock input, so several depths are allowed.
    a_irq_cause: assert property (
        $rose(irq) |-> $past(any_done) || $past(mask_wr) || $past(mask_wr, 2)
        || $past(lock_loss_reset, 2) || $past(lock_loss_reset, 3)
        || $past(lock_loss_reset, 4))
        else $error("interrupt rose without a cause");
    a_irq_clear: assert property (
        irq && wr && addr == ADDR_IRQ_STATUS && wdata == 8'hff && !any_done
        && !lock_loss_reset && !$past(lock_loss_reset)
        && !$past(lock_loss_reset, 2) |=> !irq)
        else $error("interrupt stayed after clearing all status");
    a_start_reserved: assert property (
        rd && addr == ADDR_START_ACK |=> rdata[7:3] == 5'h00)
        else $error("start register reserved bits not zero");
    a_delta_reserved: assert property (
        rd && addr == ADDR_DELTA_CFG |=> rdata[7:6] == 2'h0)
        else $error("delta register reserved bits not zero");
    a_thresh_readback: assert property (
        wr && addr == ADDR_BAT_THRESH ##1 rd && addr == ADDR_BAT_THRESH
        |=> rdata == $past(wdata, 2))
        else $error("threshold read back wrong");
    a_unmapped_zero: assert property (
        rd && addr == 8'h00 |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    c_single: cover property (go_wr && wdata[CH_TEMP]);
    c_event: cover property ($rose(irq));
    c_lock: cover property (rd && addr == ADDR_PERIPHERAL_CONFIG_REGISTER_CFG ##1 rdata[0]);
endmodule

// ---- sim/aux_adc_measure_control_test.sv ----
// Self-checking bench of the auxiliary converter control block.
`timescale 1ns/1ps

`define CHK(got, exp) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end

module aux_adc_measure_control_test
    import aam_pkg::*;
;
    logic                    clk;
    logic                    reset_n;
    logic [7:0]              addr;
    logic [7:0]              wdata;
    logic                    wr;
    logic                    rd;
    logic [7:0]              rdata;
    logic                    irq;
    logic [NCH-1:0]          conv_req;
    aam_conv_rsp_s [NCH-1:0] rsp;
    logic                    lock_in;
    logic                    rd_seen = 1'b0;
    logic [7:0]              exp_q[$];
    logic [7:0]              exp_v;
    logic [7:0]              last[NCH];
    int                      mismatches;
    int                      num_checks;
    // Minute length shortened so that background strobes fit the run.
    localparam int           MIN_CYC = 20;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    aam_measure_ctrl #(.MINUTE_CYCLES(40'(MIN_CYC))) dut (
        .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .irq(irq), .conv_req(conv_req),
        .conv_rsp(rsp), .lock_loss_reset(lock_in));

    ////////////////////////////////////////////////////////////
    // Read data stands one cycle only, so it is compared mid-cycle.
    always @(posedge clk) rd_seen <= rd & reset_n;
    always @(negedge clk) begin
        if (rd_seen) begin
            exp_v = exp_q.pop_front();
            `CHK(rdata, exp_v)
        end
    end

    task automatic idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        rd <= 1'b0;
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        wr <= 1'b0;
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
    endtask
    task automatic chk_irq(input logic e);
        idle(2);
        @(negedge clk);
        `CHK(irq, e)
        @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // The far side acknowledges, then answers in the next cycle.
    task automatic conv(input int ch, input logic [7:0] d);
        int n;
        n = 0;
        idle(1);
        // The request is polled mid-cycle, away from the edge updating it.
        @(negedge clk);
        while (conv_req[ch] !== 1'b1) begin
            n++;
            if (n > 400) begin
                mismatches++;
                wrap_up();
            end
            @(negedge clk);
        end
        @(posedge clk);
        rsp[ch].ack <= 1'b1;
        @(posedge clk);
        rsp[ch].ack <= 1'b0;
        rsp[ch].data <= d;
        rsp[ch].done <= 1'b1;
        @(posedge clk);
        rsp[ch].done <= 1'b0;
        rsp[ch].data <= ~d;
    endtask
    // The first three conversions flush a request left pending from earlier and
    // settle the phase; the last two are then exactly one period apart.
    task automatic ivl_chk(input int ch, input logic [7:0] cfg,
                           input int exp);
        time t;
        wr_reg(ADDR_STROBE_CFG, cfg);
        repeat (3) conv(ch, 8'h00);
        t = $time;
        conv(ch, 8'h00);
        `CHK(32'(($time - t) / 10), 32'(exp))
    endtask
    function automatic logic [7:0] res_addr(input int ch);
        return ch == CH_BAT ? ADDR_BAT_RESULT
             : ch == CH_TEMP ? ADDR_TEMP_RESULT : ADDR_EXT_RESULT;
    endfunction

    ////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] v;
        logic [7:0] regs[10];
        logic       hit;
        regs = '{ADDR_TEMP_RESULT, ADDR_BAT_RESULT, ADDR_EXT_RESULT,
                 ADDR_BAT_THRESH, ADDR_START_ACK, ADDR_DELTA_CFG,
                 ADDR_PERIPHERAL_CONFIG_REGISTER_CFG, ADDR_IRQ_STATUS, ADDR_IRQ_MASK,
                 ADDR_STROBE_CFG};
        {reset_n, addr, wdata, wr, rd, lock_in} = '0;
        rsp = '0;
        mismatches = 0;
        num_checks = 0;
        v = 8'($urandom(32'hc0d4));
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        foreach (regs[i]) rd_chk(regs[i], RESET_BYTE);
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            wr_reg(regs[i], v);
            rd_chk(regs[i], v);
        end
        wr_reg(ADDR_START_ACK, 8'h78);
        rd_chk(ADDR_START_ACK, 8'h00);
        wr_reg(ADDR_DELTA_CFG, 8'hff);
        rd_chk(ADDR_DELTA_CFG, DELTA_CFG_MASK);
        rd_chk(8'h00, 8'h00);
        wr_reg(ADDR_DELTA_CFG, 8'h00);
        $display("test registers done");
        wr_reg(ADDR_IRQ_MASK, IRQ_MASK_BITS);
        for (int ch = 0; ch < NCH; ch++) begin
            v = 8'($urandom_range(8'h9f, 8'h60));
            wr_reg(ADDR_START_ACK, 8'(1 << ch));
            rd_chk(ADDR_START_ACK, 8'(1 << ch));
            conv(ch, v);
            last[ch] = v;
            rd_chk(ADDR_START_ACK, 8'h00);
            rd_chk(res_addr(ch), v);
            rd_chk(ADDR_IRQ_STATUS, 8'(1 << ch));
            chk_irq(1'b1);
            wr_reg(ADDR_IRQ_STATUS, 8'hff);
            chk_irq(1'b0);
        end
        $display("test singles done");
        for (int ch = CH_TEMP; ch <= CH_EXT; ch++) begin
            wr_reg(ADDR_STROBE_CFG, ch == CH_TEMP ? 8'h03 : 8'h30);
            for (int c = 0; c < 8; c++) begin
                wr_reg(ADDR_DELTA_CFG, ch == CH_TEMP ? 8'(c << 3) : 8'(c));
                for (int k = 0; k < 2; k++) begin
                    v = (c % 2) ? 8'(last[ch] - (c + k))
                                : 8'(last[ch] + (c + k));
                    hit = (c == 7) || (c != 0 && k == 1);
                    conv(ch, v);
                    if (hit) last[ch] = v;
                    rd_chk(res_addr(ch), last[ch]);
                    rd_chk(ADDR_IRQ_STATUS,
                           hit ? 8'(1 << ch) : 8'h00);
                    wr_reg(ADDR_IRQ_STATUS, 8'hff);
                end
            end
        end
        $display("test deltas done");
        v = 8'($urandom_range(8'he0, 8'h20));
        wr_reg(ADDR_BAT_THRESH, v);
        wr_reg(ADDR_STROBE_CFG, 8'h0c);
        for (int k = 0; k < 2; k++) begin
            conv(CH_BAT, 8'(v - k));
            if (k == 1) last[CH_BAT] = 8'(v - 1);
            rd_chk(ADDR_BAT_RESULT, last[CH_BAT]);
            rd_chk(ADDR_IRQ_STATUS, 8'(k));
        end
        wr_reg(ADDR_STROBE_CFG, 8'h00);
        $display("test battery done");
        wr_reg(ADDR_IRQ_MASK, 8'h00);
        lock_in <= 1'b1;
        idle(3);
        lock_in <= 1'b0;
        idle(4);
        rd_chk(ADDR_PERIPHERAL_CONFIG_REGISTER_CFG, 8'h01);
        rd_chk(ADDR_IRQ_STATUS, 8'h09);
        chk_irq(1'b0);
        wr_reg(ADDR_IRQ_MASK, IRQ_MASK_BITS);
        chk_irq(1'b1);
        wr_reg(ADDR_START_ACK, 8'h80);
        rd_chk(ADDR_PERIPHERAL_CONFIG_REGISTER_CFG, 8'h00);
        wr_reg(ADDR_IRQ_STATUS, 8'hff);
        chk_irq(1'b0);
        $display("test lock fault done");
        ivl_chk(CH_BAT, 8'h04, int'(BAT_MIN_SLOW) * MIN_CYC);
        ivl_chk(CH_BAT, 8'h08, int'(BAT_MIN_MID) * MIN_CYC);
        ivl_chk(CH_EXT, 8'h10, int'(OTH_MIN_SLOW) * MIN_CYC);
        ivl_chk(CH_EXT, 8'h20, int'(OTH_MIN_MID) * MIN_CYC);
        ivl_chk(CH_TEMP, 8'h02, int'(OTH_MIN_MID) * MIN_CYC);
        wr_reg(ADDR_STROBE_CFG, 8'h00);
        $display("test intervals done");
        idle(4);
        wrap_up();
    end
endmodule

bind aam_measure_ctrl aam_assert_chk #(.MINUTE_CYCLES(MINUTE_CYCLES)) u_chk (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .conv_req(conv_req),
    .conv_rsp(conv_rsp), .lock_loss_reset(lock_loss_reset));
